/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic slow_mode = 0;
    logic slow_tick = 0;
    logic [2:0] modes = 0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, watchdog_interrupt, hw_init_req, reset_pin_out;
    logic reset_pin_oe_n, trap_area_active, trap_action_select, reset_wire;
    int failures = 0, checked = 0, cyc = 0, irq_count, low_cycles, t0, t1;

    always #5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    // Low-speed tick every other cycle, so slow periods are twice the tick count
    always @(posedge pclk) slow_tick <= ~slow_tick;

    watchdog_timer_unit watchdog_timer_unit_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .lo_speed_tick(slow_tick),
        .slow_mode, .stop_mode(modes[0]), .idle_mode(modes[1]), .sleep_mode(modes[2]),
        .watchdog_interrupt, .hw_init_req, .reset_pin_out, .reset_pin_oe_n,
        .trap_area_active, .trap_action_select);
    wdt_far_side wdt_far_side_inst (.pclk, .presetn, .watchdog_interrupt, .reset_pin_out,
        .reset_pin_oe_n, .reset_wire, .irq_count, .low_cycles);

    ////////////////////////////////////////
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (watchdog_interrupt !== 1'b1 && n < 6000);
        t = cyc;
    endtask

    task automatic wait_pin(input logic v);
        int n;
        n = 0;
        while (reset_wire !== v && n < 5000) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Whole run is near 30k cycles
    initial begin
        #500000;
        failures++;
        give_verdict();
    end

    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, 12'h0e0, 8'h00);
        chk(rd & 32'hfd, 32'h25);
        chk(trap_action_select, 32'h1);
        xfer(0, 12'h0d0, 8'h00);
        chk(rd, 32'h0);
        xfer(0, 12'h0d8, 8'h00);
        chk(err, 32'h1);
        xfer(1, 12'h0d0, 8'h1e);
        @(negedge pclk);
        chk(trap_area_active, 32'h1);
        xfer(1, 12'h0d4, 8'hd2);
        @(negedge pclk);
        chk(trap_area_active, 32'h0);
        xfer(1, 12'h0d0, 8'h0f);
        xfer(0, 12'h0e0, 8'h00);
        chk(rd & 32'hfd, 32'h19);
        chk(trap_action_select, 32'h0);
        // 2^11 slow ticks at one tick per two cycles: 4096 cycles
        slow_mode <= 1'b1;
        xfer(1, 12'h0d4, 8'h4e);
        wait_irq(t0);
        wait_irq(t1);
        chk(t1 - t0, 4096);
        xfer(1, 12'h0dc, 8'h01);
        slow_mode <= 1'b0;
        wait_irq(t0);
        chk(t0 - t1, 4096);
        repeat (2000) @(posedge pclk);
        xfer(1, 12'h0d4, 8'h4e);
        wait_irq(t1);
        chk(t1 - t0, 5120);
        // Counter is zero just after the wrap, so these clears keep the period
        xfer(1, 12'h0d4, 8'h4e);
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            modes <= 3'h1 << i;
            repeat (100) @(posedge pclk);
            modes <= 3'h0;
            if (i == 0) xfer(1, 12'h0d4, 8'h4e);
        end
        wait_irq(t0);
        chk(t0 - t1, 4396);
        xfer(1, 12'h0d4, 8'hb1);
        xfer(1, 12'h0d4, 8'h55);
        xfer(0, 12'h0e0, 8'h00);
        chk(rd & 32'h41, 32'h41);
        xfer(1, 12'h0dc, 8'h03);
        xfer(1, 12'h0d4, 8'h4e);
        xfer(1, 12'h0d0, 8'h16);
        xfer(1, 12'h0d4, 8'hb1);
        xfer(0, 12'h0e0, 8'h00);
        chk(rd & 32'h43, 32'h0);
        t1 = irq_count;
        repeat (3000) @(posedge pclk);
        chk(irq_count - t1, 0);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        slow_mode <= 1'b1;
        xfer(1, 12'h0d0, 8'h3f);
        xfer(1, 12'h0d4, 8'h4e);
        t0 = irq_count;
        wait_pin(1'b0);
        chk(hw_init_req, 32'h1);
        wait_pin(1'b1);
        chk(low_cycles, 24);
        chk(irq_count - t0, 0);
        xfer(0, 12'h0e0, 8'h00);
        chk(rd & 32'hfd, 32'h25);
        give_verdict();
    end
endmodule

/* File: dv/wdt_chk.sv */
`timescale 1ns/100ps
module wdt_chk (
    // Bus side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    // Power modes
    input wire logic stop_mode,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    // Actions and trap area
    input wire logic watchdog_interrupt,
    input wire logic hw_init_req,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    input wire logic trap_area_active
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [4:0] low_ff;
    logic [4:0] nxt_low;
    wire pause = stop_mode | idle_mode | sleep_mode;
    wire d2_wr = psel && penable && pwrite && pstrb[0] && paddr == 12'h0d4
        && pwdata[7:0] == 8'hd2;

    // Counts pin-low cycles so the hold length is exact
    assign nxt_low = reset_pin_oe_n ? 5'h00 : low_ff + 5'h01;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_ff <= 5'h00;
        end else begin
            low_ff <= nxt_low;
        end
    end

    ////////////////////////////////////////
    a_irq_single: assert property (watchdog_interrupt |=> !watchdog_interrupt)
        else $error("interrupt longer than one cycle");
    a_hold_len: assert property ($rose(reset_pin_oe_n) |-> low_ff == 5'h18)
        else $error("reset pin hold not 24 cycles");
    a_hold_max: assert property (low_ff <= 5'h18)
        else $error("reset pin held too long");
    a_hold_steady: assert property ($fell(reset_pin_oe_n) |=> !reset_pin_oe_n [*8])
        else $error("reset pin released early");
    a_init_pair: assert property (hw_init_req == !reset_pin_oe_n)
        else $error("init request and pin disagree");
    a_pin_low: assert property (!reset_pin_oe_n |-> !reset_pin_out)
        else $error("reset pin driven high");
    a_irq_excl: assert property (!reset_pin_oe_n |-> !watchdog_interrupt)
        else $error("interrupt during reset hold");
    a_pause_quiet: assert property (pause [*2] |-> !watchdog_interrupt && !$fell(reset_pin_oe_n))
        else $error("overflow while paused");
    a_trap_commit: assert property ($changed(trap_area_active) && $past(reset_pin_oe_n)
        |-> $past(d2_wr))
        else $error("trap area changed without commit");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("bus access not ready");

    c_irq: cover property (watchdog_interrupt);
    c_pin: cover property ($fell(reset_pin_oe_n));
    c_commit: cover property (d2_wr);
endmodule

bind watchdog_timer_unit wdt_chk wdt_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .stop_mode, .idle_mode, .sleep_mode, .watchdog_interrupt,
    .hw_init_req, .reset_pin_out, .reset_pin_oe_n, .trap_area_active);

/* File: dv/wdt_far_side.sv */
`timescale 1ns/100ps
module wdt_far_side (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // From the watchdog
    input wire logic watchdog_interrupt,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    // System view
    output logic reset_wire,
    output int irq_count,
    output int low_cycles
);
    logic last_ff;

    // Pin has a pull-up, so released means high
    assign reset_wire = reset_pin_oe_n ? 1'b1 : reset_pin_out;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_count <= 0;
            low_cycles <= 0;
            last_ff <= 1'b1;
        end else begin
            // No mask: taken whatever the global flag holds
            // Only counted; the service side never answers with a clear
            irq_count <= irq_count + int'(watchdog_interrupt);
            last_ff <= reset_wire;
            if (!reset_wire) begin
                low_cycles <= last_ff ? 1 : low_cycles + 1;
            end
        end
    end
endmodule

/* File: verilog/watchdog_params.svh */
// Overview of operation
// - Watchdog counts with its enable bit set straight after reset release.
// - Overflow action resets to reset request; software may switch it once to interrupt.
// - After a zero is written to the action bit, later ones are ignored.
// - Overflow with action one requests reset and drives the reset pin low.
// - Overflow with action zero raises the watchdog interrupt instead.
// - Counting pauses in stop, idle and sleep, then resumes from held value.
// - Divider feeds a two-stage counter; clear code clears only the counter.
// - Divider is not cleared by the clear code, so clear-to-overflow can be three quarters.
// - Detection field picks 2^25..2^19 fast or 2^17..2^11 slow periods.
// - Setup register is write-only; software must not read-modify-write it.
// - Command register obeys 4e clear, b1 disable, d2 trap commit; others ignored.
// - Disable code works only once the enable bit was written zero.
// - Setup resets to enable, action and both trap bits one, time 00.
// - With interrupt action the watchdog serves as a periodic interrupt timer.
// - While disabled the binary counter is held cleared.
// - Watchdog interrupt is non-maskable, independent of the global interrupt flag.
// - Watchdog reset holds the reset pin low at most 24 fast clock periods.
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH

// Register indexes; byte address is four times the index
`define WDT_SETUP_IDX 8'h34
`define WDT_COMMAND_IDX 8'h35
`define WDT_CONFIG_IDX 8'h37
`define WDT_STATUS_IDX 8'h38
`define WDT_PADDR_W 12

// Setup register fields
`define WDT_ACT_BIT 0
`define WDT_DT_LSB 1
`define WDT_DT_MSB 2
`define WDT_EN_BIT 3
`define WDT_TRAP_ACT_BIT 4
`define WDT_TRAP_AREA_BIT 5
`define WDT_SETUP_RESET 6'h39

// Config register fields
`define WDT_CFG_SLOW_BIT 0
`define WDT_CFG_ACK_BIT 1
`define WDT_CFG_RESET 1'h0

// Command codes
`define WDT_CODE_CLEAR 8'h4e
`define WDT_CODE_DISABLE 8'hb1
`define WDT_CODE_TRAP 8'hd2

// Divider taps: a tap period is a quarter of the detection time
`define WDT_DIV_W 23
`define WDT_TAP_FAST_BASE 5'h17
`define WDT_TAP_SLOW_BASE 5'h0f

// Reset pin hold: 24 fast clock periods, longest time so rounded down
`define WDT_CLK_PERIOD_NS 10
`define WDT_RESET_HOLD_NS 240
`define WDT_RESET_HOLD_CYC (`WDT_RESET_HOLD_NS / `WDT_CLK_PERIOD_NS)
`define WDT_HOLD_CNT_W 5

`endif

/* File: verilog/watchdog_pkg.sv */
package watchdog_pkg;

    typedef enum logic {
        HOLD_IDLE,
        HOLD_DRIVE
    } hold_state_t;

    typedef logic [1:0] stage_t;

endpackage

/* File: verilog/watchdog_timer_unit.sv */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "watchdog_params.svh"

module watchdog_timer_unit
    import watchdog_pkg::*;
#(
    parameter int PADDR_W = `WDT_PADDR_W,
    parameter int DIV_W = `WDT_DIV_W
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock source and power modes, same clock domain
    input wire logic lo_speed_tick,
    input wire logic slow_mode,
    input wire logic stop_mode,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    // Overflow actions
    output logic watchdog_interrupt,
    output logic hw_init_req,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    // Settings for the address-trap logic
    output logic trap_area_active,
    output logic trap_action_select
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [5:0] setup_ff;
    logic [5:0] nxt_setup;
    logic running_ff;
    logic nxt_running;
    logic slow_tap_ff;
    logic nxt_slow_tap;
    logic ignored_ff;
    logic nxt_ignored;
    logic trap_area_ff;
    logic nxt_trap_area;
    stage_t stage_ff;
    stage_t nxt_stage;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic irq_ff;
    logic nxt_irq;
    hold_state_t hold_ff;
    hold_state_t nxt_hold;
    logic [`WDT_HOLD_CNT_W-1:0] hold_cnt_ff;
    logic [`WDT_HOLD_CNT_W-1:0] nxt_hold_cnt;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    wire setup_phase = psel & ~penable;
    wire access_phase = psel & penable;
    wire [7:0] addr_idx = paddr[9:2];
    wire addr_clean = (paddr[PADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0);
    wire hit_setup = addr_clean && (addr_idx == `WDT_SETUP_IDX);
    wire hit_command = addr_clean && (addr_idx == `WDT_COMMAND_IDX);
    wire hit_config = addr_clean && (addr_idx == `WDT_CONFIG_IDX);
    wire hit_status = addr_clean && (addr_idx == `WDT_STATUS_IDX);
    wire mapped = hit_setup | hit_command | hit_config | hit_status;
    wire bad_access = ~mapped | (pwrite & hit_status);
    wire wr_ok = access_phase & pwrite & pstrb[0] & ~bad_access;
    wire [7:0] wdata = pwdata[7:0];

    wire wr_setup = wr_ok & hit_setup;
    wire wr_command = wr_ok & hit_command;
    wire wr_config = wr_ok & hit_config;

    // Zero wait states; errors only on unmapped or read-only targets
    assign pready = 1'b1;
    assign pslverr = access_phase & bad_access;
    assign prdata = prdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Command decode

    wire code_clear = wdata == `WDT_CODE_CLEAR;
    wire code_disable = wdata == `WDT_CODE_DISABLE;
    wire code_trap = wdata == `WDT_CODE_TRAP;
    wire do_clear = wr_command & code_clear;
    wire do_trap = wr_command & code_trap;
    // Disable only counts after the enable bit was already written low
    wire do_disable = wr_command & code_disable & ~setup_ff[`WDT_EN_BIT];
    wire cmd_ignored = wr_command & ~do_clear & ~do_trap & ~do_disable;

    ////////////////////////////////////////////////////////////////////////
    // Clock selection and divider

    wire [1:0] det_time = setup_ff[`WDT_DT_MSB:`WDT_DT_LSB];
    wire act_reset = setup_ff[`WDT_ACT_BIT];
    wire paused = stop_mode | idle_mode | sleep_mode;
    // Slow clocking or the slow tap both count low-speed ticks
    wire use_slow = slow_mode | slow_tap_ff;
    wire [4:0] tap_base = use_slow ? `WDT_TAP_SLOW_BASE : `WDT_TAP_FAST_BASE;
    wire [4:0] tap_sel = tap_base - {2'h0, det_time, 1'b0};
    wire advance = ~paused & (use_slow ? lo_speed_tick : 1'b1);
    wire hold_done = (hold_ff == HOLD_DRIVE) && (hold_cnt_ff == '0);
    // Reinit only once the pin hold ends, so the pin never sees a short pulse
    wire reinit = hold_done;
    wire tap_pulse;

    // Divider is never touched by the clear code, only by a full reinit
    wdt_divider #(
        .WIDTH(DIV_W)
    ) u_divider (
        .clk(pclk),
        .rst_n(presetn),
        .clr(reinit),
        .advance(advance),
        .tap_sel(tap_sel),
        .tap_pulse(tap_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // Overflow detection

    wire counting = running_ff & (hold_ff == HOLD_IDLE);
    // Clear on the overflow tap wins, so a timely clear never fires
    wire overflow = counting & ~do_clear & tap_pulse & (stage_ff == 2'h3);
    wire start_reset = overflow & act_reset;
    wire raise_irq = overflow & ~act_reset;

    ////////////////////////////////////////////////////////////////////////
    // Setup register and enable state

    always_comb begin
        nxt_setup = setup_ff;
        if (reinit) begin
            nxt_setup = `WDT_SETUP_RESET;
        end else if (wr_setup) begin
            nxt_setup = wdata[5:0];
            // Action bit may only fall: once interrupt, stays interrupt
            nxt_setup[`WDT_ACT_BIT] = act_reset & wdata[`WDT_ACT_BIT];
        end
    end

    always_comb begin
        nxt_running = running_ff;
        if (reinit) begin
            nxt_running = 1'b1;
        end else if (wr_setup && wdata[`WDT_EN_BIT]) begin
            nxt_running = 1'b1;
        end else if (do_disable) begin
            nxt_running = 1'b0;
        end
    end

    always_comb begin
        nxt_trap_area = trap_area_ff;
        if (reinit) begin
            nxt_trap_area = 1'(`WDT_SETUP_RESET >> `WDT_TRAP_AREA_BIT);
        end else if (do_trap) begin
            nxt_trap_area = setup_ff[`WDT_TRAP_AREA_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Config register and ignored-code flag

    wire ack_ignored = wr_config & wdata[`WDT_CFG_ACK_BIT];

    always_comb begin
        nxt_slow_tap = slow_tap_ff;
        if (reinit) begin
            nxt_slow_tap = `WDT_CFG_RESET;
        end else if (wr_config) begin
            nxt_slow_tap = wdata[`WDT_CFG_SLOW_BIT];
        end
    end

    // A new ignored code in the acknowledge cycle still sets the flag
    assign nxt_ignored = cmd_ignored | (ignored_ff & ~ack_ignored & ~reinit);

    ////////////////////////////////////////////////////////////////////////
    // Two-stage binary counter

    always_comb begin
        nxt_stage = stage_ff;
        if (!running_ff || reinit) begin
            nxt_stage = 2'h0;
        end else if (do_clear) begin
            nxt_stage = 2'h0;
        end else if (counting && tap_pulse) begin
            // Wraps on overflow so interrupt mode repeats periodically
            nxt_stage = stage_ff + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset pin hold

    // Count loaded one short: the drive state itself covers the last cycle
    always_comb begin
        nxt_hold = hold_ff;
        nxt_hold_cnt = hold_cnt_ff;
        case (hold_ff)
            HOLD_IDLE: begin
                if (start_reset) begin
                    nxt_hold = HOLD_DRIVE;
                    nxt_hold_cnt = `WDT_HOLD_CNT_W'(`WDT_RESET_HOLD_CYC - 1);
                end
            end
            HOLD_DRIVE: begin
                if (hold_cnt_ff == '0) begin
                    nxt_hold = HOLD_IDLE;
                end else begin
                    nxt_hold_cnt = hold_cnt_ff - `WDT_HOLD_CNT_W'(1);
                end
            end
            default: begin
                nxt_hold = HOLD_IDLE;
                nxt_hold_cnt = '0;
            end
        endcase
    end

    // Non-maskable: no global interrupt flag gates this request
    assign nxt_irq = raise_irq;

    ////////////////////////////////////////////////////////////////////////
    // Read data

    // Debug view only; software must not rely on it for control
    wire [7:0] status_byte = {
        hold_ff == HOLD_DRIVE,
        ignored_ff,
        trap_area_ff,
        det_time,
        act_reset,
        stage_ff == 2'h3,
        running_ff
    };
    wire [31:0] cfg_word = {30'h0, ignored_ff, slow_tap_ff};
    // Setup and command are write-only and read as zero
    wire [31:0] rd_mux = hit_config ? cfg_word :
                         hit_status ? {24'h0, status_byte} : 32'h0;

    // Captured in setup so the data stands through the whole access cycle
    assign nxt_prdata = (setup_phase & ~pwrite) ? rd_mux : prdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_ff <= `WDT_SETUP_RESET;
            running_ff <= 1'b1;
            trap_area_ff <= 1'b1;
            slow_tap_ff <= `WDT_CFG_RESET;
            ignored_ff <= 1'b0;
        end else begin
            setup_ff <= nxt_setup;
            running_ff <= nxt_running;
            trap_area_ff <= nxt_trap_area;
            slow_tap_ff <= nxt_slow_tap;
            ignored_ff <= nxt_ignored;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_ff <= 2'h0;
            irq_ff <= 1'b0;
            hold_ff <= HOLD_IDLE;
            hold_cnt_ff <= '0;
            prdata_ff <= 32'h0;
        end else begin
            stage_ff <= nxt_stage;
            irq_ff <= nxt_irq;
            hold_ff <= nxt_hold;
            hold_cnt_ff <= nxt_hold_cnt;
            prdata_ff <= nxt_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign watchdog_interrupt = irq_ff;
    assign hw_init_req = hold_ff == HOLD_DRIVE;
    // Open drain: only ever pulls low
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_n = hold_ff != HOLD_DRIVE;
    assign trap_area_active = trap_area_ff;
    assign trap_action_select = setup_ff[`WDT_TRAP_ACT_BIT];

endmodule

/* File: verilog/wdt_divider.sv */
`timescale 1ns/100ps

module wdt_divider #(
    parameter int WIDTH = 23
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire logic advance,
    input wire logic [4:0] tap_sel,
    // Tap output
    output logic tap_pulse
);

    logic [WIDTH-1:0] cnt_ff;
    logic [WIDTH-1:0] nxt_cnt;
    logic [WIDTH-1:0] mask;

    // Low tap_sel bits all ones marks one tap period
    assign mask = WIDTH'((64'h1 << tap_sel) - 64'h1);
    assign nxt_cnt = clr ? '0 : (advance ? cnt_ff + WIDTH'(1) : cnt_ff);
    assign tap_pulse = advance & ~clr & ((cnt_ff & mask) == mask);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule
